// >>> hw/pbs_pkg.sv
// package for the power-on reset and boot sequencer
// assumes one 10 MHz system clock and a synchronous active-high reset
package pbs_pkg;

    // =======================================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int BOOT_FIXED_NS = 2000000;
    localparam int BOOT_PER_KB_NS = 3600000;
    localparam int KB_BYTES = 1024;
    localparam int DEBUG_START_NS = 1000000;
    localparam int BOOT_FIXED_CYC = BOOT_FIXED_NS / CLK_PERIOD_NS;
    localparam int BYTE_CYC = BOOT_PER_KB_NS / (CLK_PERIOD_NS * KB_BYTES);
    localparam int DEBUG_START_CYC = DEBUG_START_NS / CLK_PERIOD_NS;
    localparam int POR_STABLE_CYC = 16;

    // =======================================================
    // widths and reset values
    localparam int COUNT_W = 24;
    localparam int PACE_W = 6;
    localparam int ADDR_W = 12;
    localparam int LEN_W = 13;
    localparam int RAM_DEPTH = 4096;
    localparam int GPIO_W = 10;
    localparam logic [GPIO_W-1:0] GPIO_IDLE = 10'h3FF;
    localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
    localparam logic [7:0] PORT_OD_RST = 8'hFF;
    localparam logic [15:0] BOOT_START_ADDR = 16'h0000;
    localparam logic [1:0] OSC_SRC_INTERNAL = 2'h0;
    localparam logic [PACE_W-1:0] PACE_DATA_READY = 6'h02;

    // =======================================================
    // types
    typedef enum {
        S_HOLD, S_FIXED, S_COPY, S_DEBUG, S_RUN, S_OFF
    } pbs_state_t;

    typedef struct packed {
        logic cpuHalt;
        logic regInit;
        logic intrDisable;
        logic timerDisable;
        logic fetchEnable;
    } pbs_ctrl_t;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] openDrain;
    } pbs_port_t;

    localparam pbs_ctrl_t CTRL_RESET = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    localparam pbs_port_t PORT_RESET = '{PORT_LATCH_RST, PORT_OD_RST};

endpackage

// >>> hw/pbs_por_filter.sv
// power-good stability filter
// assumes porOk is synchronous to clk
`timescale 1ns/1ns
module pbs_por_filter
    import pbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic porOk,
    output logic stable
);
    logic [PACE_W-1:0] cnt;

    // =======================================================
    // count consecutive good cycles, any dip restarts
    always_ff @(posedge clk)
    begin
        if (rst || restart || !porOk)
        begin
            cnt <= '0;
            stable <= 1'b0;
        end
        else if (cnt == PACE_W'(POR_STABLE_CYC - 1))
            stable <= 1'b1;
        else
            cnt <= cnt + 1'b1;
    end
endmodule

// >>> hw/pbs_code_ram.sv
// code/data ram loaded at boot, one write and one registered read port
// assumes no reset: contents survive any reset while powered
`timescale 1ns/1ns
module pbs_code_ram
    import pbs_pkg::*;
(
    input wire logic clk,
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [RAM_DEPTH];

    // =======================================================
    // write and registered read
    always_ff @(posedge clk)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule

// >>> hw/pbs_sequencer.sv
// power-on reset and boot sequencer, top level
// assumes porOk comes from the regulator, nvm has one-cycle read latency
`timescale 1ns/1ns
module pbs_sequencer
    import pbs_pkg::*;
#(
    parameter int FIXED_CYCLES = BOOT_FIXED_CYC,
    parameter int DEBUG_CYCLES = DEBUG_START_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic porOk,
    input wire logic debugResetReq,
    input wire logic shutdownReq,
    input wire logic [GPIO_W-1:0] gpioIn,
    input wire logic nvmProgrammed,
    input wire logic [LEN_W-1:0] copyBytes,
    output logic [ADDR_W-1:0] nvmAddr,
    input wire logic [7:0] nvmData,
    input wire logic [ADDR_W-1:0] cpuAddr,
    output logic [7:0] cpuData,
    input wire pbs_pkg::pbs_port_t portReg,
    input wire logic [1:0] oscSelReg,
    output pbs_pkg::pbs_ctrl_t ctrl,
    output pbs_pkg::pbs_port_t port,
    output logic [15:0] programCounter,
    output logic [1:0] oscSel,
    output logic powerEnable
);
    import pbs_pkg::*;

    pbs_state_t state;
    pbs_state_t next_state;
    logic [COUNT_W-1:0] stateCnt;
    logic [PACE_W-1:0] paceCnt;
    logic [LEN_W-1:0] copyIdx;
    logic [LEN_W-1:0] copyLen;
    logic porStable;
    logic filterRestart;
    logic ramWe;
    logic lastByte;
    logic fixedDone;
    logic debugDone;

    // =======================================================
    // decoding
    // any gpio pulled low is a wake request
    function automatic logic isWake(input logic [GPIO_W-1:0] pins);
        return pins != GPIO_IDLE;
    endfunction

    // =======================================================
    // power-good filter
    // restart on debug reset or while unpowered
    assign filterRestart = debugResetReq || state == S_OFF;

    pbs_por_filter uFilter (
        .clk(clk),
        .rst(rst),
        .restart(filterRestart),
        .porOk(porOk),
        .stable(porStable)
    );

    // =======================================================
    // sequence decode
    assign fixedDone = stateCnt == COUNT_W'(FIXED_CYCLES - 1);
    assign debugDone = stateCnt == COUNT_W'(DEBUG_CYCLES - 1);
    assign lastByte = copyIdx + 1'b1 == copyLen;

    // next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            S_HOLD:
                if (porStable)
                    next_state = nvmProgrammed ? S_FIXED : S_DEBUG;
            S_FIXED:
                if (fixedDone)
                    next_state = copyLen == '0 ? S_RUN : S_COPY;
            S_COPY:
                if (paceCnt == PACE_W'(BYTE_CYC - 1) && lastByte)
                    next_state = S_RUN;
            S_DEBUG:
                if (debugDone)
                    next_state = S_RUN;
            S_RUN:
                if (shutdownReq)
                    next_state = S_OFF;
            S_OFF:
                if (isWake(gpioIn))
                    next_state = S_HOLD;
        endcase
        if (debugResetReq && state != S_OFF)
            next_state = S_HOLD;
    end

    // state register, power-on returns to hold
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= S_HOLD;
        else
            state <= next_state;
    end

    // cycles spent in the current state
    always_ff @(posedge clk)
    begin
        if (rst || next_state != state)
            stateCnt <= '0;
        else if (stateCnt != '1)
            stateCnt <= stateCnt + 1'b1;
    end

    // =======================================================
    // nvm to ram copy
    // length reloaded every cycle in hold, held once hold is left
    always_ff @(posedge clk)
    begin
        if (rst)
            copyLen <= '0;
        else if (state == S_HOLD)
            copyLen <= copyBytes;
    end

    // byte pacing and index, fresh for every boot
    always_ff @(posedge clk)
    begin
        if (rst || state != S_COPY)
        begin
            paceCnt <= '0;
            copyIdx <= '0;
        end
        else if (paceCnt == PACE_W'(BYTE_CYC - 1))
        begin
            paceCnt <= '0;
            copyIdx <= copyIdx + 1'b1;
        end
        else
            paceCnt <= paceCnt + 1'b1;
    end

    // nvm address follows the byte index
    always_ff @(posedge clk)
    begin
        if (rst)
            nvmAddr <= '0;
        else
            nvmAddr <= copyIdx[ADDR_W-1:0];
    end

    // write once per byte after read latency
    assign ramWe = state == S_COPY && paceCnt == PACE_DATA_READY;

    // ram has no reset, so debug restarts keep loaded code
    pbs_code_ram uRam (
        .clk(clk),
        .we(ramWe),
        .waddr(copyIdx[ADDR_W-1:0]),
        .wdata(nvmData),
        .raddr(cpuAddr),
        .rdata(cpuData)
    );

    // =======================================================
    // processor and peripheral control
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl <= CTRL_RESET;
        else
        begin
            ctrl.cpuHalt <= next_state != S_RUN;
            ctrl.regInit <= next_state == S_HOLD || next_state == S_OFF;
            ctrl.intrDisable <= next_state != S_RUN;
            ctrl.timerDisable <= next_state != S_RUN;
            ctrl.fetchEnable <= next_state == S_RUN;
        end
    end

    // port pins parked until running
    always_ff @(posedge clk)
    begin
        if (rst || next_state != S_RUN)
            port <= PORT_RESET;
        else
            port <= portReg;
    end

    // program counter cleared and clock internal until running
    always_ff @(posedge clk)
    begin
        if (rst || next_state != S_RUN)
        begin
            programCounter <= BOOT_START_ADDR;
            oscSel <= OSC_SRC_INTERNAL;
        end
        else
            oscSel <= oscSelReg;
    end

    // internal supply removed in shutdown
    always_ff @(posedge clk)
    begin
        if (rst)
            powerEnable <= 1'b1;
        else
            powerEnable <= next_state != S_OFF;
    end

    // =======================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_copyEnd;
        state == S_COPY ##1 state == S_RUN;
    endsequence

    sequence s_wakeSeen;
        state == S_OFF && isWake(gpioIn) && !rst;
    endsequence

    a_halt_not_run: assert property (
        state != S_RUN |-> ctrl.cpuHalt)
        else $error("processor not halted outside run");
    a_reg_init: assert property (
        state == S_HOLD && next_state == S_HOLD |=> ctrl.regInit)
        else $error("register init not held in reset");
    a_irq_timer_off: assert property (
        ctrl.cpuHalt |-> ctrl.intrDisable && ctrl.timerDisable)
        else $error("interrupts or timers live during reset");
    a_port_parked: assert property (
        !ctrl.fetchEnable |-> port == PORT_RESET)
        else $error("port not parked during reset");
    a_pc_clock_exit: assert property (
        $rose(ctrl.fetchEnable) |->
            programCounter == BOOT_START_ADDR &&
            $past(oscSel) == OSC_SRC_INTERNAL)
        else $error("boot exit without cleared counter or internal clock");
    a_fetch_after_copy: assert property (
        s_copyEnd |-> ctrl.fetchEnable && !ctrl.cpuHalt)
        else $error("fetch not enabled at copy end");
    a_no_fetch_boot: assert property (
        state inside {S_HOLD, S_FIXED, S_COPY, S_DEBUG} |->
            !ctrl.fetchEnable)
        else $error("fetch enabled during boot");
    a_copy_pace: assert property (
        ramWe |=> !ramWe [*8])
        else $error("ram bytes written too fast");
    a_copy_address: assert property (
        ramWe |-> nvmAddr == copyIdx[ADDR_W-1:0])
        else $error("ram byte not paired with its nvm address");
    a_debug_short: assert property (
        state == S_DEBUG |-> stateCnt < COUNT_W'(DEBUG_CYCLES))
        else $error("short startup overran");
    a_debug_keep_ram: assert property (
        state == S_HOLD && !nvmProgrammed ##1 state == S_DEBUG |->
            !ramWe)
        else $error("ram written on unprogrammed part");
    a_wake_restart: assert property (
        s_wakeSeen |=> state == S_HOLD ##1 ctrl.regInit)
        else $error("wake did not restart reset");
    a_hold_until_good: assert property (
        state == S_HOLD && !porStable && !debugResetReq |=>
            state == S_HOLD)
        else $error("boot left hold before power good");
    a_filter_restart: assert property (
        state == S_OFF |=> !porStable)
        else $error("power good filter not restarted in shutdown");
    a_shutdown_power: assert property (
        state == S_RUN && shutdownReq && !debugResetReq |=>
            !powerEnable && state == S_OFF)
        else $error("shutdown did not remove power");

    // levels that must agree with the state in every cycle
    a_power_level: assert property (
        powerEnable == (state != S_OFF))
        else $error("supply enable disagrees with shutdown state");
    a_osc_internal: assert property (
        state != S_RUN |->
            oscSel == OSC_SRC_INTERNAL && programCounter == BOOT_START_ADDR)
        else $error("clock or counter not at defaults outside run");
    a_port_follow: assert property (
        ctrl.fetchEnable |-> port == $past(portReg))
        else $error("port does not follow its register while running");
endmodule

// >>> verif/pbs_buttons.sv
// far-side model: wake buttons, debug adapter and nvm read port
// assumes sampling on the rising edge of the system clock
`timescale 1ns/1ns
module pbs_buttons
    import pbs_pkg::*;
(
    input wire logic clk,
    input wire logic press,
    input wire logic [3:0] pressBit,
    input wire logic dbgPress,
    input wire logic [ADDR_W-1:0] nvmAddr,
    output logic [GPIO_W-1:0] gpioIn,
    output logic debugResetReq,
    output logic [7:0] nvmData
);
    // ==================================================
    // pins and adapter
    // a pressed button grounds one pin, pull-ups hold the rest
    always_ff @(posedge clk)
        gpioIn <= press ? ~(GPIO_W'(1) << pressBit) : GPIO_IDLE;
    // reset through the debug chain only
    always_ff @(posedge clk)
        debugResetReq <= dbgPress;
    // nvm answers one cycle after the address
    always_ff @(posedge clk)
        nvmData <= 8'(nvmAddr * 7) + 8'h3C;
endmodule

// >>> verif/pbs_sequencer_tb_top.sv
// self-checking bench for the reset and boot sequencer
// assumes short boot counts and the button model beside it
`timescale 1ns/1ns
module pbs_sequencer_tb_top;
    import pbs_pkg::*;
    localparam int FIX = 40;
    localparam int DBG = 20;
    logic clk, rst, porOk, shutdownReq, nvmProgrammed, press, dbgPress;
    logic [3:0] pressBit;
    logic [GPIO_W-1:0] gpioIn;
    logic debugResetReq, powerEnable;
    logic [LEN_W-1:0] copyBytes;
    logic [ADDR_W-1:0] nvmAddr, cpuAddr;
    logic [7:0] nvmData, cpuData;
    pbs_port_t portReg, port;
    logic [1:0] oscSelReg, oscSel;
    pbs_ctrl_t ctrl;
    logic [15:0] programCounter;
    int errors, cmp_count, len;

    // ==================================================
    // instances
    pbs_sequencer #(.FIXED_CYCLES(FIX), .DEBUG_CYCLES(DBG)) pbs_sequencer_i
    (
        .clk(clk), .rst(rst), .porOk(porOk),
        .debugResetReq(debugResetReq), .shutdownReq(shutdownReq),
        .gpioIn(gpioIn), .nvmProgrammed(nvmProgrammed),
        .copyBytes(copyBytes), .nvmAddr(nvmAddr), .nvmData(nvmData),
        .cpuAddr(cpuAddr), .cpuData(cpuData), .portReg(portReg),
        .oscSelReg(oscSelReg), .ctrl(ctrl), .port(port),
        .programCounter(programCounter), .oscSel(oscSel),
        .powerEnable(powerEnable)
    );
    pbs_buttons pbs_buttons_i
    (
        .clk(clk), .press(press), .pressBit(pressBit),
        .dbgPress(dbgPress), .nvmAddr(nvmAddr), .gpioIn(gpioIn),
        .debugResetReq(debugResetReq), .nvmData(nvmData)
    );

    // ==================================================
    // helpers
    initial
    begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    function automatic logic [7:0] nvm_byte(input int i);
        return 8'(i * 7) + 8'h3C;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // cycles from leaving hold until user fetch
    task automatic boot(input int expc);
        int n;
        n = 0;
        while (ctrl.regInit !== 1'b0 && n < 2000)
        begin
            tick(1);
            n++;
        end
        n = 0;
        while (ctrl.fetchEnable !== 1'b1 && n < 9000)
        begin
            tick(1);
            n++;
        end
        cmp_count++;
        if (n < expc - 2 || n > expc + 2)
        begin
            errors++;
            $display("Error boot expected %0d seen %0d", expc, n);
        end
    endtask
    task automatic ramchk(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            cpuAddr <= ADDR_W'(i);
            tick(2);
            chk("ram", {8'h00, nvm_byte(i)}, {8'h00, cpuData});
        end
    endtask
    task automatic pulse_shutdown();
        @(posedge clk);
        shutdownReq <= 1;
        @(posedge clk);
        shutdownReq <= 0;
        tick(1);
    endtask
    task automatic pulse_debug();
        @(posedge clk);
        dbgPress <= 1;
        tick(2);
        dbgPress <= 0;
        tick(2);
    endtask
    task automatic complete_run();
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog well past the expected run
    initial
    begin
        #(20000 * 100);
        errors++;
        complete_run();
    end

    // ==================================================
    // tests
    initial
    begin
        errors = 0;
        cmp_count = 0;
        rst = 1;
        porOk = 0;
        shutdownReq = 0;
        nvmProgrammed = 1;
        press = 0;
        pressBit = 0;
        dbgPress = 0;
        cpuAddr = 0;
        portReg = '0;
        oscSelReg = '0;
        void'($urandom(85162));
        len = 1 + int'($urandom % 4);
        copyBytes = LEN_W'(len);
        tick(20);
        chk("ctrl", 16'(CTRL_RESET), 16'(ctrl));
        chk("port", PORT_RESET, port);
        chk("progcnt", BOOT_START_ADDR, programCounter);
        chk("osc", 16'(OSC_SRC_INTERNAL), 16'(oscSel));
        @(posedge clk);
        rst <= 0;
        porOk <= 1;
        portReg <= pbs_port_t'($urandom);
        oscSelReg <= 2'($urandom);
        tick(10);
        porOk <= 0;
        @(posedge clk);
        porOk <= 1;
        tick(12);
        chk("hold", 16'h0001, 16'(ctrl.regInit));
        $display("test reset done");
        boot(FIX + len * 35);
        chk("progcnt", BOOT_START_ADDR, programCounter);
        chk("runctrl", 16'h0001, 16'(ctrl));
        chk("port", portReg, port);
        chk("osc", 16'(oscSelReg), 16'(oscSel));
        ramchk(len);
        $display("test programmed boot done");
        nvmProgrammed <= 0;
        pulse_debug();
        chk("dbgfetch", 16'h0000, 16'(ctrl.fetchEnable));
        pulse_shutdown();
        chk("swpower", 16'h0001, 16'(powerEnable));
        boot(DBG);
        ramchk(len);
        $display("test debug boot done");
        pulse_shutdown();
        chk("offpower", 16'h0000, 16'(powerEnable));
        chk("offhalt", 16'h0001, 16'(ctrl.cpuHalt));
        pulse_debug();
        chk("offdbg", 16'h0000, 16'(powerEnable));
        nvmProgrammed <= 1;
        copyBytes <= '0;
        pressBit <= 4'($urandom % 10);
        press <= 1;
        tick(3);
        press <= 0;
        chk("wake", 16'h0001, 16'(powerEnable));
        boot(FIX);
        $display("test wake done");
        complete_run();
    end
endmodule
